//--- pkg/dashp_regs.svh
`ifndef DASHP_REGS_SVH
`define DASHP_REGS_SVH
// Host register byte offsets
`define DASHP_OFS_CTRL 5'h00
`define DASHP_OFS_MODE 5'h04
`define DASHP_OFS_TXWORD 5'h08
`define DASHP_OFS_RESULT 5'h0c
`define DASHP_OFS_LATCH 5'h10
`define DASHP_OFS_COUNT 5'h14
`define DASHP_OFS_LINE 5'h18
// Host register bit positions
`define DASHP_CTRL_START 0
`define DASHP_CTRL_INIT 1
`define DASHP_LINE_TX 0
`define DASHP_LINE_TX_EN 1
`define DASHP_LINE_RX 2
// Configuration word fields
`define DASHP_OP_MSB 15
`define DASHP_OP_LSB 12
`define DASHP_OP_WR_CFG 4'h8
`define DASHP_OP_WR_REF_A 4'h9
`define DASHP_OP_WR_REF_B 4'ha
`define DASHP_CFG_MODE_MSB 10
`define DASHP_CFG_MODE_LSB 9
// Reset values
`define DASHP_RST_CFG 12'h000
`define DASHP_RST_REF 12'h000
`define DASHP_RST_HOST_MODE 2'h0
// Initialisation words
`define DASHP_INIT_REF_A 16'h9ff8
`define DASHP_INIT_REF_B 16'haff8
`define DASHP_INIT_CFG 16'h8640
// Timing
`define DASHP_CLK_NS 25
`define DASHP_SCLK_MAX_MHZ 24
`define DASHP_SCLK_PERIOD_NS 400
`define DASHP_SCLK_HALF_CYC ((`DASHP_SCLK_PERIOD_NS / 2 + `DASHP_CLK_NS - 1) / `DASHP_CLK_NS)
`define DASHP_CONV_NS 1000
`define DASHP_CONV_CYC ((`DASHP_CONV_NS + `DASHP_CLK_NS - 1) / `DASHP_CLK_NS)
`endif

//--- pkg/dashp_pkg.sv
package dashp_pkg;
   // Interface modes, field value of the configuration word
   typedef enum logic [1:0] {
      MODE_DUAL32 = 2'h0,
      MODE_DUAL16 = 2'h1,
      MODE_SINGLE16 = 2'h2,
      MODE_SINGLE32 = 2'h3
   } dashp_mode_e;

   // Host frame sequencer, Gray along the usual path
   typedef enum logic [1:0] {
      HS_IDLE = 2'h0,
      HS_LEAD = 2'h1,
      HS_CLOCK = 2'h3,
      HS_TAIL = 2'h2
   } dashp_host_state_e;

   // Falling clock edges a frame needs to be valid
   function automatic logic [5:0] req_falls(input dashp_mode_e m);
      case (m)
         MODE_DUAL32: req_falls = 6'h20;
         MODE_SINGLE32: req_falls = 6'h30;
         MODE_DUAL16: req_falls = 6'h10;
         default: req_falls = 6'h20;
      endcase
   endfunction

   // Falling edges before the first data bit stands on the pin
   function automatic logic [5:0] data_skip(input dashp_mode_e m);
      data_skip = (m == MODE_DUAL32 || m == MODE_SINGLE32) ? 6'h10 : 6'h00;
   endfunction

   // Both channels leave on output A
   function automatic logic is_single(input dashp_mode_e m);
      is_single = (m == MODE_SINGLE32 || m == MODE_SINGLE16);
   endfunction
endpackage

//--- pkg/dashp_link_if.sv
`timescale 1ns/1ps
interface dashp_link_if;
   logic sel_n;
   logic sclk;
   logic serial_config_in;
   logic serial_result_out_a;
   logic serial_result_out_a_oe;
   logic serial_result_out_b;
   logic serial_result_out_b_oe;
   logic line_tx;
   logic line_tx_en;
   logic line_rx;
   logic sine_square_wave;
   logic cosine_square_wave;
   logic result_a_pin;
   logic result_b_pin;

   // Undriven result pins float high through a pull-up
   assign result_a_pin = serial_result_out_a_oe ? serial_result_out_a : 1'b1;
   assign result_b_pin = serial_result_out_b_oe ? serial_result_out_b : 1'b1;

   modport converter (
      input sel_n, sclk, serial_config_in, line_tx, line_tx_en,
      output serial_result_out_a, serial_result_out_a_oe,
      output serial_result_out_b, serial_result_out_b_oe,
      output line_rx, sine_square_wave, cosine_square_wave
   );

   modport host (
      output sel_n, sclk, serial_config_in, line_tx, line_tx_en,
      input result_a_pin, result_b_pin,
      input line_rx, sine_square_wave, cosine_square_wave
   );
endinterface

//--- rtl/dashp_sync_edge.sv
`timescale 1ns/1ps
module dashp_sync_edge #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Asynchronous inputs
   input wire logic [WIDTH-1:0] i_async,
   // Synchronised level and edges
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] level_ff;
   logic [WIDTH-1:0] prev_ff;

   // Two stages; edges compare the second and third only
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_ff <= '1;
         level_ff <= '1;
         prev_ff <= '1;
      end else begin
         meta_ff <= i_async;
         level_ff <= meta_ff;
         prev_ff <= level_ff;
      end
   end

   assign o_level = level_ff;
   assign o_rise = level_ff & ~prev_ff;
   assign o_fall = ~level_ff & prev_ff;
endmodule

//--- rtl/dashp_converter_end.sv
`timescale 1ns/1ps
`include "dashp_regs.svh"
module dashp_converter_end (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link toward the host
   dashp_link_if.converter link,
   // Digitised analog inputs
   input wire logic [11:0] i_sample_a,
   input wire logic [11:0] i_sample_b,
   // Encoder side signals
   input wire logic i_sine_square_wave,
   input wire logic i_cosine_square_wave,
   input wire logic i_line_rx,
   output logic o_line_tx,
   output logic o_line_tx_en,
   // Programmed registers and state
   output logic [11:0] o_reference_level_a,
   output logic [11:0] o_reference_level_b,
   output logic [11:0] o_converter_config_word,
   output logic o_tracking,
   output logic o_frame_active
);
   localparam int PSEL = 7;
   localparam int PSCLK = 6;
   localparam int PCFG = 5;
   localparam int PTX = 4;
   localparam int PTXEN = 3;
   localparam int PSIN = 2;
   localparam int PCOS = 1;
   localparam int PRX = 0;
   localparam logic [5:0] CONV_LAST = 6'(`DASHP_CONV_CYC - 1);

   logic [7:0] pin_lvl;
   logic [7:0] pin_rise;
   logic [7:0] pin_fall;
   logic frame_ff;
   logic [5:0] fall_cnt_ff;
   logic [5:0] cnt_next;
   logic [15:0] word_ff;
   logic [15:0] hold_a_ff;
   logic [15:0] hold_b_ff;
   logic [15:0] sh_a_ff;
   logic [15:0] sh_b_ff;
   logic oe_a_ff;
   logic oe_b_ff;
   logic track_ff;
   logic [5:0] conv_cnt_ff;
   logic [11:0] cfg_ff;
   logic [11:0] ref_a_ff;
   logic [11:0] ref_b_ff;
   logic [4:0] pass_ff;
   logic sel_start;
   logic sel_end;
   logic sclk_fall;
   logic long_mode;
   logic single;
   dashp_pkg::dashp_mode_e mode;

   // Sign extension of a 12-bit code to the output word
   function automatic logic [15:0] to_word(input logic [11:0] code);
      to_word = {{4{code[11]}}, code};
   endfunction

   // All link inputs are asynchronous to i_clk
   dashp_sync_edge #(.WIDTH(8)) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({link.sel_n, link.sclk, link.serial_config_in, link.line_tx,
                link.line_tx_en, i_sine_square_wave, i_cosine_square_wave, i_line_rx}),
      .o_level(pin_lvl),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   assign mode = dashp_pkg::dashp_mode_e'(cfg_ff[`DASHP_CFG_MODE_MSB:`DASHP_CFG_MODE_LSB]);
   assign long_mode = (dashp_pkg::data_skip(mode) != 6'h00);
   assign single = dashp_pkg::is_single(mode);
   assign sel_start = pin_fall[PSEL];
   assign sel_end = pin_rise[PSEL] & frame_ff;
   assign sclk_fall = pin_fall[PSCLK] & frame_ff;
   // Saturates so that overlong frames still count as valid
   assign cnt_next = (fall_cnt_ff == 6'h3f) ? 6'h3f : fall_cnt_ff + 6'h01;

   // Frame spans select low
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         frame_ff <= 1'b0;
      end else if (sel_start) begin
         frame_ff <= 1'b1;
      end else if (sel_end) begin
         frame_ff <= 1'b0;
      end
   end

   // Falling edge count and incoming word, MSB first
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fall_cnt_ff <= 6'h00;
         word_ff <= 16'h0000;
      end else if (sel_start) begin
         fall_cnt_ff <= 6'h00;
         word_ff <= 16'h0000;
      end else if (sclk_fall) begin
         fall_cnt_ff <= cnt_next;
         if (fall_cnt_ff < 6'h10) begin
            word_ff <= {word_ff[14:0], pin_lvl[PCFG]};
         end
      end
   end

   // Sample hold at the frame start
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hold_a_ff <= 16'h0000;
         hold_b_ff <= 16'h0000;
      end else if (sel_start) begin
         hold_a_ff <= to_word(i_sample_a);
         hold_b_ff <= to_word(i_sample_b);
      end
   end

   // Conversion timer on the internal clock, then back to tracking
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         track_ff <= 1'b1;
         conv_cnt_ff <= 6'h00;
      end else if (sel_start) begin
         track_ff <= 1'b0;
         conv_cnt_ff <= 6'h00;
      end else if (!track_ff) begin
         conv_cnt_ff <= conv_cnt_ff + 6'h01;
         // An early select rise aborts the conversion as well
         if (conv_cnt_ff == CONV_LAST || sel_end) begin
            track_ff <= 1'b1;
         end
      end
   end

   // Result shifters; in long modes output A shows zero until the 16th fall
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sh_a_ff <= 16'h0000;
         sh_b_ff <= 16'h0000;
      end else if (sel_start) begin
         // Short modes have no conversion gap, data leave at once
         sh_a_ff <= long_mode ? 16'h0000 : to_word(i_sample_a);
         sh_b_ff <= long_mode ? 16'h0000 : to_word(i_sample_b);
      end else if (sclk_fall) begin
         if (long_mode && cnt_next == 6'h10) begin
            sh_a_ff <= hold_a_ff;
            sh_b_ff <= hold_b_ff;
         end else begin
            // Single mode chains B behind A on the one pin
            sh_a_ff <= {sh_a_ff[14:0], single ? sh_b_ff[15] : 1'b0};
            sh_b_ff <= {sh_b_ff[14:0], 1'b0};
         end
      end
   end

   // Output drivers, released outside frames
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         oe_a_ff <= 1'b0;
         oe_b_ff <= 1'b0;
      end else if (sel_start) begin
         oe_a_ff <= 1'b1;
         oe_b_ff <= ~single;
      end else if (sel_end) begin
         oe_a_ff <= 1'b0;
         oe_b_ff <= 1'b0;
      end
   end

   // Register commit only for complete frames
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cfg_ff <= `DASHP_RST_CFG;
         ref_a_ff <= `DASHP_RST_REF;
         ref_b_ff <= `DASHP_RST_REF;
      end else if (sel_end && fall_cnt_ff >= dashp_pkg::req_falls(mode)) begin
         case (word_ff[`DASHP_OP_MSB:`DASHP_OP_LSB])
            `DASHP_OP_WR_CFG: cfg_ff <= word_ff[11:0];
            `DASHP_OP_WR_REF_A: ref_a_ff <= word_ff[11:0];
            `DASHP_OP_WR_REF_B: ref_b_ff <= word_ff[11:0];
            default: cfg_ff <= cfg_ff; // Reads and no-ops change nothing
         endcase
      end
   end

   // Line and quadrature signals pass through, one flop past sync
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         // Idle high like the synchronisers, so the host sees no false edge
         pass_ff <= 5'h1f;
      end else begin
         pass_ff <= {pin_lvl[PTX], pin_lvl[PTXEN], pin_lvl[PSIN], pin_lvl[PCOS], pin_lvl[PRX]};
      end
   end

   assign link.serial_result_out_a = sh_a_ff[15];
   assign link.serial_result_out_a_oe = oe_a_ff;
   assign link.serial_result_out_b = sh_b_ff[15];
   assign link.serial_result_out_b_oe = oe_b_ff;
   assign o_line_tx = pass_ff[4];
   assign o_line_tx_en = pass_ff[3];
   assign link.sine_square_wave = pass_ff[2];
   assign link.cosine_square_wave = pass_ff[1];
   assign link.line_rx = pass_ff[0];
   assign o_reference_level_a = ref_a_ff;
   assign o_reference_level_b = ref_b_ff;
   assign o_converter_config_word = cfg_ff;
   assign o_tracking = track_ff;
   assign o_frame_active = frame_ff;
endmodule

//--- rtl/dashp_host_end.sv
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dashp_regs.svh"
module dashp_host_end (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Avalon-MM slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Link toward the converter board
   dashp_link_if.host link
);
   localparam logic [4:0] HALF_LAST = 5'(`DASHP_SCLK_HALF_CYC - 1);
   localparam logic [4:0] TAIL_LAST = 5'(2 * `DASHP_SCLK_HALF_CYC - 1);

   logic [4:0] pin_lvl;
   logic [4:0] pin_rise;
   logic [4:0] pin_fall;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic wr_acc;
   dashp_pkg::dashp_mode_e mode_ff;
   logic [15:0] tx_word_ff;
   logic start_req_ff;
   logic [1:0] init_step_ff;
   logic tx_ff;
   logic tx_en_ff;
   dashp_pkg::dashp_host_state_e state_ff;
   logic [4:0] div_ff;
   logic [5:0] falls_ff;
   logic sclk_ff;
   logic sel_n_ff;
   logic cfg_out_ff;
   logic [15:0] shift_ff;
   logic [31:0] cap_a_ff;
   logic [15:0] cap_b_ff;
   logic [31:0] result_ff;
   logic [15:0] latch_ff;
   logic [15:0] count_ff;
   logic half_done;
   logic go;
   logic fall_evt;
   logic rise_evt;
   logic frame_end;
   logic [15:0] go_word;
   logic qa_prev;
   logic qb_prev;

   // Register read decode
   function automatic logic [31:0] rd_mux(input logic [4:0] a);
      case (a)
         `DASHP_OFS_CTRL: rd_mux = {30'h0, init_step_ff != 2'h0, state_ff != dashp_pkg::HS_IDLE};
         `DASHP_OFS_MODE: rd_mux = {30'h0, mode_ff};
         `DASHP_OFS_TXWORD: rd_mux = {16'h0, tx_word_ff};
         `DASHP_OFS_RESULT: rd_mux = result_ff;
         `DASHP_OFS_LATCH: rd_mux = {16'h0, latch_ff};
         `DASHP_OFS_COUNT: rd_mux = {16'h0, count_ff};
         `DASHP_OFS_LINE: rd_mux = {29'h0, pin_lvl[2], tx_en_ff, tx_ff};
         default: rd_mux = 32'h0;
      endcase
   endfunction

   // Result pins, line receive and quadrature inputs
   dashp_sync_edge #(.WIDTH(5)) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({link.result_a_pin, link.result_b_pin, link.line_rx,
                link.sine_square_wave, link.cosine_square_wave}),
      .o_level(pin_lvl),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   // Bus answer: one wait cycle, then waitrequest low for one cycle
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end else begin
         wait_ff <= ~((i_avs_read | i_avs_write) & wait_ff);
         if (i_avs_read && wait_ff) begin
            rdata_ff <= rd_mux(i_avs_address);
         end
      end
   end
   assign wr_acc = i_avs_write & ~wait_ff;

   // Software settings; init forces the long single mode
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_ff <= dashp_pkg::dashp_mode_e'(`DASHP_RST_HOST_MODE);
         tx_word_ff <= 16'h0000;
         tx_ff <= 1'b1;
         tx_en_ff <= 1'b0;
      end else if (wr_acc) begin
         case (i_avs_address)
            `DASHP_OFS_CTRL: begin
               if (i_avs_writedata[`DASHP_CTRL_INIT]) begin
                  mode_ff <= dashp_pkg::MODE_SINGLE32;
               end
            end
            `DASHP_OFS_MODE: mode_ff <= dashp_pkg::dashp_mode_e'(i_avs_writedata[1:0]);
            `DASHP_OFS_TXWORD: tx_word_ff <= i_avs_writedata[15:0];
            `DASHP_OFS_LINE: begin
               tx_ff <= i_avs_writedata[`DASHP_LINE_TX];
               tx_en_ff <= i_avs_writedata[`DASHP_LINE_TX_EN];
            end
            default: tx_ff <= tx_ff;
         endcase
      end
   end

   // Frame requests; a new request wins over the clear
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         start_req_ff <= 1'b0;
         init_step_ff <= 2'h0;
      end else begin
         if (wr_acc && i_avs_address == `DASHP_OFS_CTRL && i_avs_writedata[`DASHP_CTRL_START]) begin
            start_req_ff <= 1'b1;
         end else if (go && init_step_ff == 2'h0) begin
            start_req_ff <= 1'b0;
         end
         if (wr_acc && i_avs_address == `DASHP_OFS_CTRL && i_avs_writedata[`DASHP_CTRL_INIT]) begin
            init_step_ff <= 2'h1;
         end else if (frame_end && init_step_ff != 2'h0) begin
            init_step_ff <= (init_step_ff == 2'h3) ? 2'h0 : init_step_ff + 2'h1;
         end
      end
   end

   // Fixed sequence: both references, then configuration
   always_comb begin
      case (init_step_ff)
         2'h1: go_word = `DASHP_INIT_REF_A;
         2'h2: go_word = `DASHP_INIT_REF_B;
         2'h3: go_word = `DASHP_INIT_CFG;
         default: go_word = tx_word_ff;
      endcase
   end

   assign half_done = (div_ff == HALF_LAST);
   assign go = (state_ff == dashp_pkg::HS_IDLE) & (start_req_ff | (init_step_ff != 2'h0));
   assign fall_evt = half_done & ((state_ff == dashp_pkg::HS_LEAD) |
                     ((state_ff == dashp_pkg::HS_CLOCK) & sclk_ff &
                      (falls_ff != dashp_pkg::req_falls(mode_ff))));
   assign rise_evt = half_done & (state_ff == dashp_pkg::HS_CLOCK) & ~sclk_ff;
   assign frame_end = (state_ff == dashp_pkg::HS_TAIL) & (div_ff == TAIL_LAST);

   // Frame sequencer; divided serial clock idles high, 2.5 MHz
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_ff <= dashp_pkg::HS_IDLE;
         div_ff <= 5'h00;
      end else begin
         div_ff <= (half_done && state_ff != dashp_pkg::HS_TAIL) ? 5'h00 : div_ff + 5'h01;
         case (state_ff)
            dashp_pkg::HS_IDLE: begin
               div_ff <= 5'h00;
               if (go) begin
                  state_ff <= dashp_pkg::HS_LEAD;
               end
            end
            dashp_pkg::HS_LEAD: if (half_done) begin
               state_ff <= dashp_pkg::HS_CLOCK;
            end
            dashp_pkg::HS_CLOCK: if (half_done && sclk_ff && !fall_evt) begin
               state_ff <= dashp_pkg::HS_TAIL;
               div_ff <= 5'h00;
            end
            dashp_pkg::HS_TAIL: if (frame_end) begin
               state_ff <= dashp_pkg::HS_IDLE;
            end
            default: state_ff <= dashp_pkg::HS_IDLE;
         endcase
      end
   end

   // Link pins: select, clock and outgoing word
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sel_n_ff <= 1'b1;
         sclk_ff <= 1'b1;
         cfg_out_ff <= 1'b0;
         shift_ff <= 16'h0000;
         falls_ff <= 6'h00;
      end else if (go) begin
         sel_n_ff <= 1'b0;
         cfg_out_ff <= go_word[15];
         shift_ff <= {go_word[14:0], 1'b0};
         falls_ff <= 6'h00;
      end else if (fall_evt) begin
         sclk_ff <= 1'b0;
         falls_ff <= falls_ff + 6'h01;
      end else if (rise_evt) begin
         sclk_ff <= 1'b1;
         cfg_out_ff <= shift_ff[15];
         shift_ff <= {shift_ff[14:0], 1'b0};
      end else if (state_ff == dashp_pkg::HS_TAIL && div_ff == HALF_LAST) begin
         sel_n_ff <= 1'b1;
      end
   end

   // Data bits after the skipped falls, channel A first
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cap_a_ff <= 32'h0;
         cap_b_ff <= 16'h0;
         result_ff <= 32'h0;
      end else begin
         if (fall_evt && falls_ff >= dashp_pkg::data_skip(mode_ff)) begin
            cap_a_ff <= {cap_a_ff[30:0], pin_lvl[4]};
            cap_b_ff <= {cap_b_ff[14:0], pin_lvl[3]};
         end
         if (frame_end) begin
            result_ff <= dashp_pkg::is_single(mode_ff) ? cap_a_ff :
                         {cap_a_ff[15:0], cap_b_ff};
         end
      end
   end

   // Quadrature count, latched as select falls
   assign qa_prev = pin_lvl[1] ^ pin_rise[1] ^ pin_fall[1];
   assign qb_prev = pin_lvl[0] ^ pin_rise[0] ^ pin_fall[0];
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_ff <= 16'h0000;
         latch_ff <= 16'h0000;
      end else begin
         if ((pin_lvl[1] ^ qa_prev) | (pin_lvl[0] ^ qb_prev)) begin
            count_ff <= (pin_lvl[1] ^ qb_prev) ? count_ff + 16'h0001 : count_ff - 16'h0001;
         end
         if (go) begin
            latch_ff <= count_ff;
         end
      end
   end

   assign o_avs_readdata = rdata_ff;
   assign o_avs_waitrequest = wait_ff;
   assign link.sel_n = sel_n_ff;
   assign link.sclk = sclk_ff;
   assign link.serial_config_in = cfg_out_ff;
   assign link.line_tx = tx_ff;
   assign link.line_tx_en = tx_en_ff;
endmodule

//--- test/dashp_assertions.sv
`timescale 1ns/1ps
module dashp_assertions (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link signals
   input wire logic i_sel_n,
   input wire logic i_sclk,
   input wire logic i_serial_result_out_a,
   input wire logic i_serial_result_out_a_oe,
   input wire logic i_serial_result_out_b_oe
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   logic sclk_ff;
   logic [5:0] falls_ff;
   logic [3:0] age_ff;
   // Falls per frame and age of last fall; age saturates so idle never looks fresh
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sclk_ff <= 1'b1;
         falls_ff <= 6'h00;
         age_ff <= 4'hf;
      end else begin
         sclk_ff <= i_sclk;
         if ($fell(i_sel_n)) begin
            falls_ff <= 6'h00;
         end else if (sclk_ff && !i_sclk) begin
            falls_ff <= falls_ff + 6'h01;
         end
         if (sclk_ff && !i_sclk) begin
            age_ff <= 4'h0;
         end else if (age_ff != 4'hf) begin
            age_ff <= age_ff + 4'h1;
         end
      end
   end
   sequence s_open;
      $fell(i_sel_n);
   endsequence
   sequence s_zero;
      ##[1:6] (i_serial_result_out_a_oe && !i_serial_result_out_a);
   endsequence
   property p_zero;
      s_open |-> s_zero;
   endproperty
   property p_release;
      i_sel_n [*8] |-> !i_serial_result_out_a_oe && !i_serial_result_out_b_oe;
   endproperty
   property p_in_frame;
      (i_serial_result_out_a_oe || i_serial_result_out_b_oe) |-> !$past(i_sel_n, 2)
         || !$past(i_sel_n, 3) || !$past(i_sel_n, 4) || !$past(i_sel_n, 5);
   endproperty
   property p_shift;
      i_serial_result_out_a_oe && $past(i_serial_result_out_a_oe)
         && $changed(i_serial_result_out_a) |-> age_ff inside {[1:6]};
   endproperty
   property p_idle;
      i_sel_n |-> i_sclk;
   endproperty
   property p_half;
      $changed(i_sclk) |=> $stable(i_sclk) [*7];
   endproperty
   property p_falls;
      $rose(i_sel_n) |-> falls_ff inside {6'h10, 6'h20, 6'h30};
   endproperty
   property p_gap;
      $rose(i_sel_n) |-> i_sel_n [*7];
   endproperty
   a_zero: assert property (p_zero)
      else $error("Output A not low at frame start");
   a_release: assert property (p_release)
      else $error("Output still driven after frame");
   a_in_frame: assert property (p_in_frame)
      else $error("Output driven outside frame");
   a_shift: assert property (p_shift)
      else $error("Output A moved away from a clock fall");
   a_idle: assert property (p_idle)
      else $error("Serial clock low outside frame");
   a_half: assert property (p_half)
      else $error("Serial clock half period short");
   a_falls: assert property (p_falls)
      else $error("Wrong fall count in frame");
   a_gap: assert property (p_gap)
      else $error("Frame gap too short");
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "dashp_regs.svh"
module tb_top;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata, q;
   logic [11:0] smp_a = 12'h801;
   logic [11:0] smp_b = 12'h7ff;
   logic [11:0] ref_a, ref_b, cfg;
   logic single = 1'b0;
   logic [1:0] quad = 2'h3;
   logic tx, tx_en, trk, wait_r, frm;
   int n_mismatch = 0;
   int samples_checked = 0;
   int b_drv = 0;
   dashp_link_if link ();
   // Clock, 25 ns
   initial forever #12.5 i_clk = ~i_clk;
   dashp_host_end i_dashp_host_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .link(link));
   dashp_converter_end i_dashp_converter_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .link(link), .i_sample_a(smp_a), .i_sample_b(smp_b), .i_sine_square_wave(quad[1]),
      .i_cosine_square_wave(quad[0]), .i_line_rx(1'b1), .o_line_tx(tx), .o_line_tx_en(tx_en),
      .o_reference_level_a(ref_a), .o_reference_level_b(ref_b),
      .o_converter_config_word(cfg), .o_tracking(trk), .o_frame_active(frm));
   dashp_assertions i_dashp_assertions (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_sel_n(link.sel_n), .i_sclk(link.sclk),
      .i_serial_result_out_a(link.serial_result_out_a),
      .i_serial_result_out_a_oe(link.serial_result_out_a_oe),
      .i_serial_result_out_b_oe(link.serial_result_out_b_oe));
   // Pin B must stay released in single mode
   always @(posedge i_clk) if (single && link.serial_result_out_b_oe !== 1'b0) b_drv++;
   task finish_test();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // Held until waitrequest seen low at a rising edge; data taken there
   task av(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (wait_r !== 1'b0 && k < 64);
      if (k >= 64) begin
         n_mismatch++;
         finish_test();
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Poll until neither frame nor init is running
   task idle();
      int k;
      k = 0;
      do begin
         av(1'b0, `DASHP_OFS_CTRL, 32'h0);
         k++;
      end while (q[1:0] !== 2'h0 && k < 2000);
      if (k >= 2000) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   // Dual frame, init, single frame, short frame, line bits
   initial begin
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      av(1'b0, `DASHP_OFS_LINE, 32'h0);
      chk("line", 32'h5, q);
      // Quarter steps 01, 00, 10, 11 with sine leading: four counts up
      for (int s = 0; s < 4; s++) begin
         quad <= 2'(8'he1 >> (2 * s));
         repeat (8) @(posedge i_clk);
      end
      av(1'b0, `DASHP_OFS_COUNT, 32'h0);
      chk("count", 32'h4, q);
      av(1'b1, 5'h1c, 32'hffff_ffff);
      av(1'b0, 5'h1c, 32'h0);
      chk("unmapped", 32'h0, q);
      av(1'b1, `DASHP_OFS_TXWORD, 32'h9abc);
      av(1'b1, `DASHP_OFS_CTRL, 32'h1);
      // Count moves only after the select fall, so the latch must keep 4
      quad <= 2'h1;
      idle();
      chk("ref_a", 32'habc, 32'(ref_a));
      chk("frame", 32'h0, 32'(frm));
      av(1'b0, `DASHP_OFS_LATCH, 32'h0);
      chk("latch", 32'h4, q);
      av(1'b0, `DASHP_OFS_RESULT, 32'h0);
      chk("dual", 32'hf801_07ff, q);
      chk("track", 32'h1, 32'(trk));
      av(1'b1, `DASHP_OFS_CTRL, 32'h2);
      idle();
      chk("cfg", 32'h640, 32'(cfg));
      av(1'b0, `DASHP_OFS_MODE, 32'h0);
      chk("mode", 32'h3, q);
      smp_a <= 12'hfff;
      smp_b <= 12'h123;
      single <= 1'b1;
      av(1'b1, `DASHP_OFS_TXWORD, 32'ha123);
      av(1'b1, `DASHP_OFS_CTRL, 32'h1);
      idle();
      chk("ref_b", 32'h123, 32'(ref_b));
      av(1'b0, `DASHP_OFS_RESULT, 32'h0);
      chk("single", 32'hffff_0123, q);
      chk("oe_b", 32'h0, 32'(b_drv));
      av(1'b1, `DASHP_OFS_MODE, 32'h1);
      av(1'b1, `DASHP_OFS_TXWORD, 32'h9555);
      av(1'b1, `DASHP_OFS_CTRL, 32'h1);
      idle();
      chk("short", 32'hff8, 32'(ref_a));
      av(1'b1, `DASHP_OFS_LINE, 32'h2);
      repeat (8) @(posedge i_clk);
      chk("tx", 32'h2, {30'h0, tx_en, tx});
      finish_test();
   end
endmodule
